// *** rtl/bcd_pkg.sv ***
package bcd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction word fields
  localparam int          OPC_MSB        = 15;
  localparam int          OPC_LSB        = 11;
  localparam logic [4:0]  OPC_GROUP      = 5'h07;  // Shared control group code
  localparam logic [4:0]  OPC_CALL_DIR   = 5'h1c;  // Direct call
  localparam logic [2:0]  OPC_JUMP_HIGH  = 3'h3;   // Upper bits of 011pp jump
  localparam logic [3:0]  F3_TABLE_CALL  = 4'h0;
  localparam logic [3:0]  F3_JUMP_IND    = 4'h4;
  localparam logic [3:0]  F3_CALL_IND    = 4'h5;
  localparam logic [3:0]  F3_RETURN      = 4'he;
  localparam logic [3:0]  F3_CONTROL     = 4'hf;
  localparam logic [2:0]  F2_ZERO        = 3'h0;
  localparam logic [2:0]  F2_RET_PLAIN   = 3'h0;
  localparam logic [2:0]  F2_RET_SKIP    = 3'h1;
  localparam logic [2:0]  F2_RET_INT     = 3'h4;
  localparam logic [2:0]  F2_INT_ON      = 3'h0;
  localparam logic [2:0]  F2_INT_OFF     = 3'h1;
  localparam logic [2:0]  F2_STOP        = 3'h2;
  localparam logic [2:0]  F2_WAIT        = 3'h3;
  localparam logic [2:0]  F2_IDLE        = 3'h4;
  localparam logic [3:0]  F4_ZERO        = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Register port map, word indices
  localparam logic [3:0]  REG_JUMP_TARGET = 4'h0;
  localparam logic [3:0]  REG_STATUS      = 4'h1;
  localparam int          ST_SP_LSB       = 16;
  localparam int          ST_GATE         = 20;
  localparam int          ST_SYSCALL      = 21;
  localparam int          ST_STOP         = 22;
  localparam int          ST_WAIT         = 23;
  localparam int          ST_SKIP         = 24;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [12:0] RST_PC          = 13'h0000;
  localparam logic [12:0] RST_JUMP_TARGET = 13'h0000;
  localparam logic [3:0]  RST_CONTEXT     = 4'h0;
  localparam logic [3:0]  RST_COND        = 4'h0;

  typedef enum logic [1:0] {
    BCD_RUN  = 2'b00,
    BCD_STOP = 2'b01,
    BCD_WAIT = 2'b10
  } bcd_state_e;

endpackage : bcd_pkg

// *** rtl/bcd_stack_if.sv ***
`timescale 1ns/1ps
// Return stack access: push and the level it lands on, top word back
interface bcd_stack_if #(
  parameter int AW = 3,
  parameter int DW = 13
);
  logic          push;
  logic [AW-1:0] level_next;
  logic [DW-1:0] push_data;
  logic [DW-1:0] top;

  modport ctl (output push, output level_next, output push_data, input top);
  modport mem (input push, input level_next, input push_data, output top);
endinterface : bcd_stack_if

// *** rtl/bcd_return_stack.sv ***
`timescale 1ns/1ps
module bcd_return_stack #(
  parameter int AW = 3,
  parameter int DW = 13
) (
  input wire logic  clock,
  input wire logic  sys_rst,
  bcd_stack_if.mem  stk
);

  logic [DW-1:0] mem_reg [2**AW];

  ////////////////////////////////////////////////////////////////////////////
  // Storage; sized to the full level range so an empty level still indexes safely
  always_ff @(posedge clock) begin
    if (stk.push) begin
      mem_reg[stk.level_next] <= stk.push_data;
    end
  end

  // Top word tracks the level being entered; a push forwards its own data
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      stk.top <= '0;
    end else if (stk.push) begin
      stk.top <= stk.push_data;
    end else begin
      stk.top <= mem_reg[stk.level_next];
    end
  end

endmodule : bcd_return_stack

// *** rtl/bcd_branch_decoder.sv ***
//
// Behaviour
// - The indirect jump loads the whole counter from jump_target_reg and pushes nothing.
// - A direct call lowers the stack level, pushes the return address, loads counter bits 10-0 from the field and clears the page.
// - The indirect call lowers the stack level, pushes the return address and loads the counter from jump_target_reg.
// - The table call pushes, sets system_call_flag, clears bits 12,11 and 7-4 and places the entry in bits 10-8 and 3-0.
// - A plain return reloads the counter from return_stack_top and raises the stack level.
// - The skipping return acts like a return and then skips the instruction at the restored address.
// - The interrupt return also restores int_context_regs from int_saved_context.
// - The interrupt-on word sets global_int_gate and the interrupt-off word clears it.
// - The stop word enters the oscillator-stop state with its low nibble as release condition.
// - The wait word enters the clock-running wait state with its low nibble as wake condition.
// - The idle word only advances the counter.
// - Every group word starts with 00111 and splits the rest into 3, 4 and 4 bit fields.
// - On a single-page part the direct jump loads only counter bits 10-0.
// - On multi-page parts the direct jump also sets the page from the low two code bits, within the pages present.
//
`timescale 1ns/1ps
module bcd_branch_decoder #(
  parameter int PC_W           = 13,
  parameter int NUM_PAGES      = 4,
  parameter int HAS_TABLE_CALL = 1,
  parameter int STACK_DEPTH    = 5
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic [15:0] instr_word,
  input  wire logic        instr_valid,
  input  wire logic        wake_event,
  input  wire logic [3:0]  int_saved_context,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  output logic [PC_W-1:0]  fetch_addr,
  output logic             global_int_gate,
  output logic             system_call_flag,
  output logic      [3:0]  int_context_regs,
  output logic             stop_active,
  output logic             wait_active,
  output logic      [3:0]  wake_cond,
  output logic      [3:0]  stack_level_ptr
);

  localparam int SP_W = $clog2(STACK_DEPTH + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks
  if (PC_W != 13) begin : g_bad_pc
    $error("bcd_branch_decoder: counter width must be 13");
  end
  if (NUM_PAGES < 1 || NUM_PAGES > 4) begin : g_bad_pages
    $error("bcd_branch_decoder: page count must be 1 to 4");
  end
  if (STACK_DEPTH < 1 || STACK_DEPTH > 15) begin : g_bad_depth
    $error("bcd_branch_decoder: stack depth must be 1 to 15");
  end

  bcd_pkg::bcd_state_e state_reg;
  logic [PC_W-1:0]     pc_reg;
  logic [PC_W-1:0]     pc_next;
  logic [PC_W-1:0]     pc_inc;
  logic [PC_W-1:0]     jump_target_reg;
  logic [SP_W-1:0]     sp_reg;
  logic [SP_W-1:0]     sp_next;
  logic                skip_reg;
  logic [PC_W-1:0]     return_stack_top;

  bcd_stack_if #(.AW(SP_W), .DW(PC_W)) stk ();

  bcd_return_stack #(.AW(SP_W), .DW(PC_W)) u_stack (
    .clock   (clock),
    .sys_rst (sys_rst),
    .stk     (stk.mem)
  );

  assign return_stack_top = stk.top;

  ////////////////////////////////////////////////////////////////////////////
  // Field split and decode
  logic [4:0] f_opc;
  logic [2:0] f2;
  logic [3:0] f3;
  logic [3:0] f4;
  logic       exec_ok;
  logic       in_group;
  logic       is_jump_dir, is_call_dir, is_jump_ind, is_call_ind, is_table;
  logic       is_ret, is_ret_skip, is_ret_int, is_int_on, is_int_off;
  logic       is_stop, is_wait, is_push, is_pop;
  logic [1:0] jump_page;

  assign f_opc    = instr_word[bcd_pkg::OPC_MSB:bcd_pkg::OPC_LSB];
  assign f2       = instr_word[10:8];
  assign f3       = instr_word[7:4];
  assign f4       = instr_word[3:0];
  assign jump_page = f_opc[1:0];
  // A skipped slot still consumes the word but does nothing else
  assign exec_ok  = instr_valid && (state_reg == bcd_pkg::BCD_RUN) && !skip_reg;
  assign in_group = exec_ok && (f_opc == bcd_pkg::OPC_GROUP);

  // Absent pages and a missing table call fall through as idle words
  assign is_jump_dir = exec_ok && (f_opc[4:2] == bcd_pkg::OPC_JUMP_HIGH)
                       && (32'(jump_page) < NUM_PAGES);
  assign is_call_dir = exec_ok && (f_opc == bcd_pkg::OPC_CALL_DIR);
  assign is_jump_ind = in_group && f2 == bcd_pkg::F2_ZERO && f3 == bcd_pkg::F3_JUMP_IND
                       && f4 == bcd_pkg::F4_ZERO;
  assign is_call_ind = in_group && f2 == bcd_pkg::F2_ZERO && f3 == bcd_pkg::F3_CALL_IND
                       && f4 == bcd_pkg::F4_ZERO;
  assign is_table    = in_group && f3 == bcd_pkg::F3_TABLE_CALL
                       && (HAS_TABLE_CALL != 0);
  assign is_ret      = in_group && f3 == bcd_pkg::F3_RETURN && f4 == bcd_pkg::F4_ZERO
                       && f2 == bcd_pkg::F2_RET_PLAIN;
  assign is_ret_skip = in_group && f3 == bcd_pkg::F3_RETURN && f4 == bcd_pkg::F4_ZERO
                       && f2 == bcd_pkg::F2_RET_SKIP;
  assign is_ret_int  = in_group && f3 == bcd_pkg::F3_RETURN && f4 == bcd_pkg::F4_ZERO
                       && f2 == bcd_pkg::F2_RET_INT;
  assign is_int_on   = in_group && f3 == bcd_pkg::F3_CONTROL && f4 == bcd_pkg::F4_ZERO
                       && f2 == bcd_pkg::F2_INT_ON;
  assign is_int_off  = in_group && f3 == bcd_pkg::F3_CONTROL && f4 == bcd_pkg::F4_ZERO
                       && f2 == bcd_pkg::F2_INT_OFF;
  assign is_stop     = in_group && f3 == bcd_pkg::F3_CONTROL && f2 == bcd_pkg::F2_STOP;
  assign is_wait     = in_group && f3 == bcd_pkg::F3_CONTROL && f2 == bcd_pkg::F2_WAIT;
  assign is_push     = is_call_dir || is_call_ind || is_table;
  assign is_pop      = is_ret || is_ret_skip || is_ret_int;

  ////////////////////////////////////////////////////////////////////////////
  // Next counter value; return address is the word after the call
  assign pc_inc = pc_reg + PC_W'(1);

  always_comb begin
    pc_next = pc_reg;
    if (exec_ok || (instr_valid && state_reg == bcd_pkg::BCD_RUN)) begin
      pc_next = pc_inc;
    end
    if (is_jump_ind || is_call_ind) begin
      pc_next = jump_target_reg;
    end else if (is_jump_dir) begin
      pc_next[10:0] = instr_word[10:0];
      if (NUM_PAGES > 1) begin
        pc_next[12:11] = jump_page;
      end
    end else if (is_call_dir) begin
      pc_next = {2'b00, instr_word[10:0]};
    end else if (is_table) begin
      pc_next = {2'b00, f2, 4'h0, f4};
    end else if (is_pop) begin
      pc_next = return_stack_top;
    end
  end

  // Calls step the level down, returns step it up
  always_comb begin
    sp_next = sp_reg;
    if (is_push) begin
      sp_next = sp_reg - SP_W'(1);
    end else if (is_pop) begin
      sp_next = sp_reg + SP_W'(1);
    end
  end

  assign stk.push       = is_push;
  assign stk.level_next = sp_next;
  assign stk.push_data  = pc_inc;

  ////////////////////////////////////////////////////////////////////////////
  // Counter and stack level
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pc_reg <= bcd_pkg::RST_PC;
      sp_reg <= SP_W'(STACK_DEPTH);
    end else begin
      pc_reg <= pc_next;
      sp_reg <= sp_next;
    end
  end

  // Skip marker: the returned-to word is consumed as an idle slot
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      skip_reg <= 1'b0;
    end else if (is_ret_skip) begin
      skip_reg <= 1'b1;
    end else if (instr_valid && state_reg == bcd_pkg::BCD_RUN) begin
      skip_reg <= 1'b0;
    end
  end

  // Interrupt gate and restored context
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      global_int_gate  <= 1'b0;
      int_context_regs <= bcd_pkg::RST_CONTEXT;
    end else begin
      if (is_int_on) begin
        global_int_gate <= 1'b1;
      end else if (is_int_off) begin
        global_int_gate <= 1'b0;
      end
      if (is_ret_int) begin
        int_context_regs <= int_saved_context;
      end
    end
  end

  // Table-call marker stays set; no clear path exists in this group
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      system_call_flag <= 1'b0;
    end else if (is_table) begin
      system_call_flag <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low-power states; the counter already points past the entry word
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= bcd_pkg::BCD_RUN;
      wake_cond <= bcd_pkg::RST_COND;
    end else begin
      case (state_reg)
        bcd_pkg::BCD_RUN: begin
          if (is_stop) begin
            state_reg <= bcd_pkg::BCD_STOP;
            wake_cond <= f4;
          end else if (is_wait) begin
            state_reg <= bcd_pkg::BCD_WAIT;
            wake_cond <= f4;
          end
        end
        bcd_pkg::BCD_STOP, bcd_pkg::BCD_WAIT: begin
          if (wake_event) begin
            state_reg <= bcd_pkg::BCD_RUN;
          end
        end
        default: begin
          state_reg <= bcd_pkg::BCD_RUN;
        end
      endcase
    end
  end

  assign stop_active     = (state_reg == bcd_pkg::BCD_STOP);
  assign wait_active     = (state_reg == bcd_pkg::BCD_WAIT);
  assign fetch_addr      = pc_reg;
  assign stack_level_ptr = 4'(sp_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Register port: jump target is written, status is read back
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      jump_target_reg <= bcd_pkg::RST_JUMP_TARGET;
    end else if (reg_write && reg_addr == bcd_pkg::REG_JUMP_TARGET) begin
      jump_target_reg <= reg_wdata[PC_W-1:0];
    end
  end

  // Read data stand only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_read) begin
      reg_rdata <= 32'h0000_0000;
      case (reg_addr)
        bcd_pkg::REG_JUMP_TARGET: begin
          reg_rdata[PC_W-1:0] <= jump_target_reg;
        end
        bcd_pkg::REG_STATUS: begin
          reg_rdata[PC_W-1:0]                       <= pc_reg;
          reg_rdata[bcd_pkg::ST_SP_LSB+:4]          <= 4'(sp_reg);
          reg_rdata[bcd_pkg::ST_GATE]               <= global_int_gate;
          reg_rdata[bcd_pkg::ST_SYSCALL]            <= system_call_flag;
          reg_rdata[bcd_pkg::ST_STOP]               <= stop_active;
          reg_rdata[bcd_pkg::ST_WAIT]               <= wait_active;
          reg_rdata[bcd_pkg::ST_SKIP]               <= skip_reg;
        end
        default: begin
          reg_rdata <= 32'h0000_0000;
        end
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_jump_ind_load: assert property (is_jump_ind |=> fetch_addr == $past(jump_target_reg)
    && stack_level_ptr == $past(stack_level_ptr)) else $error("indirect jump wrong");
  a_call_dir_push: assert property (is_call_dir |=> fetch_addr[10:0] == $past(instr_word[10:0])
    && fetch_addr[12:11] == 2'b00 && stack_level_ptr == $past(stack_level_ptr) - 4'h1)
    else $error("direct call wrong");
  a_call_ind_push: assert property (is_call_ind ##1 is_pop |=>
    fetch_addr == $past(fetch_addr, 2) + PC_W'(1)) else $error("indirect call return wrong");
  a_call_ind_load: assert property (is_call_ind |=>
    fetch_addr == $past(jump_target_reg) && stack_level_ptr == $past(stack_level_ptr) - 4'h1)
    else $error("indirect call load wrong");
  a_table_call_load: assert property (is_table |=> system_call_flag
    && fetch_addr[7:4] == 4'h0 && fetch_addr[10:8] == $past(f2)) else $error("table call wrong");
  a_return_pop: assert property (is_ret |=> fetch_addr == $past(return_stack_top)
    && stack_level_ptr == $past(stack_level_ptr) + 4'h1) else $error("return wrong");
  a_skip_idle: assert property (is_ret_skip ##1 (instr_valid && !stop_active && !wait_active)
    |=> fetch_addr == $past(fetch_addr) + PC_W'(1)
    && stack_level_ptr == $past(stack_level_ptr)) else $error("skip slot not idle");
  a_op_return_int_context: assert property (is_ret_int |=> int_context_regs == $past(int_saved_context))
    else $error("context not restored");
  a_gate_on_off: assert property ((is_int_on |=> global_int_gate)
    and (is_int_off |=> !global_int_gate)) else $error("gate wrong");
  a_stop_entry: assert property (is_stop |=> stop_active && wake_cond == $past(f4))
    else $error("stop entry wrong");
  a_wait_entry: assert property (is_wait |=> wait_active && wake_cond == $past(f4))
    else $error("wait entry wrong");
  a_idle_only: assert property ((in_group && f2 == bcd_pkg::F2_IDLE && f3 == bcd_pkg::F3_CONTROL)
    |=> fetch_addr == $past(fetch_addr) + PC_W'(1) && $stable(stack_level_ptr)
    && $stable(global_int_gate)) else $error("idle word changed state");
  a_jump_page_sel: assert property ((is_jump_dir && NUM_PAGES > 1)
    |=> fetch_addr[12:11] == $past(jump_page)) else $error("page not set");

endmodule : bcd_branch_decoder

// *** tb/bcd_prog_mem.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Program memory model: one 16-bit word per address, read without delay
module bcd_prog_mem #(
  parameter int AW = 13
) (
  input  wire logic [AW-1:0] fetch_addr,
  output logic      [15:0]   instr_word
);
  logic [15:0] mem [0:(1<<AW)-1];

  // Unwritten words hold the idle word, so a stray fetch never repeats an old branch
  initial begin
    for (int i = 0; i < (1 << AW); i++) begin
      mem[i] = {bcd_pkg::OPC_GROUP, bcd_pkg::F2_IDLE, bcd_pkg::F3_CONTROL, bcd_pkg::F4_ZERO};
    end
  end

  // Word follows the counter at once; the bench decides when a slot is taken
  assign instr_word = mem[fetch_addr];
endmodule : bcd_prog_mem

// *** tb/test_bcd_branch_decoder.sv ***
`timescale 1ns/1ps
module test_bcd_branch_decoder;
  logic        clock;
  logic        sys_rst;
  logic        instr_valid;
  logic        wake_event;
  logic [3:0]  int_saved_context;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_write;
  logic        reg_read;
  logic [31:0] reg_rdata;
  logic [15:0] instr_word;
  logic [12:0] fetch_addr;
  logic        global_int_gate;
  logic        system_call_flag;
  logic [3:0]  int_context_regs;
  logic        stop_active;
  logic        wait_active;
  logic [3:0]  wake_cond;
  logic [3:0]  stack_level_ptr;
  int          err_count    = 0;
  int          total_checks = 0;
  int          cycles       = 0;

  bcd_branch_decoder dut (
    .clock(clock), .sys_rst(sys_rst), .instr_word(instr_word), .instr_valid(instr_valid),
    .wake_event(wake_event), .int_saved_context(int_saved_context), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .fetch_addr(fetch_addr), .global_int_gate(global_int_gate),
    .system_call_flag(system_call_flag), .int_context_regs(int_context_regs),
    .stop_active(stop_active), .wait_active(wait_active), .wake_cond(wake_cond),
    .stack_level_ptr(stack_level_ptr)
  );

  bcd_prog_mem pm (.fetch_addr(fetch_addr), .instr_word(instr_word));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; the whole run needs well under a thousand cycles
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic summarize();
    if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask : chk

  // One instruction slot with the word placed at the given address
  task automatic slot(input logic [12:0] a, input logic [15:0] w);
    pm.mem[a] = w;
    @(posedge clock);
    instr_valid <= 1'b1;
    @(posedge clock);
    instr_valid <= 1'b0;
    #1;
  endtask : slot

  task automatic st(input logic [12:0] pc, input logic [3:0] lvl);
    chk("fetch_addr", {19'h0, pc}, {19'h0, fetch_addr});
    chk("stack_level_ptr", {28'h0, lvl}, {28'h0, stack_level_ptr});
  endtask : st

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  // Read data is taken in the one cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk("reg_rdata", exp, reg_rdata);
  endtask : rd

  task automatic wake();
    @(posedge clock);
    wake_event <= 1'b1;
    @(posedge clock);
    wake_event <= 1'b0;
    #1;
  endtask : wake

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset_regs();
    st(13'h0000, 4'h5);
    chk("outputs", 32'h0, {20'h0, global_int_gate, system_call_flag, int_context_regs,
                           stop_active, wait_active, wake_cond});
    rd(bcd_pkg::REG_STATUS, 32'h0005_0000);
    wr(bcd_pkg::REG_JUMP_TARGET, 32'h0000_0abc);
    rd(bcd_pkg::REG_JUMP_TARGET, 32'h0000_0abc);
    @(posedge clock);
    #1;
    chk("reg_rdata idle", 32'h0, reg_rdata);
    wr(bcd_pkg::REG_STATUS, 32'hffff_ffff);
    rd(bcd_pkg::REG_STATUS, 32'h0005_0000);
    rd(4'h5, 32'h0);
  endtask : t_reset_regs

  task automatic t_jumps_calls();
    slot(13'h0000, 16'h3840);
    st(13'h0abc, 4'h5);
    slot(13'h0abc, 16'he123);
    st(13'h0123, 4'h4);
    slot(13'h0123, 16'h38e0);
    st(13'h0abd, 4'h5);
    wr(bcd_pkg::REG_JUMP_TARGET, 32'h0000_1a55);
    slot(13'h0abd, 16'h3850);
    st(13'h1a55, 4'h4);
  endtask : t_jumps_calls

  // The call after a skipping return must be consumed as an idle slot
  task automatic t_skip();
    pm.mem[13'h0abe] = 16'he000;
    slot(13'h1a55, 16'h39e0);
    st(13'h0abe, 4'h5);
    rd(bcd_pkg::REG_STATUS, 32'h0105_0abe);
    slot(13'h0abe, 16'he000);
    st(13'h0abf, 4'h5);
  endtask : t_skip

  task automatic t_table_op_return_int();
    int_saved_context <= 4'ha;
    slot(13'h0abf, 16'h3b09);
    st(13'h0309, 4'h4);
    chk("system_call_flag", 32'h1, {31'h0, system_call_flag});
    slot(13'h0309, 16'h3ce0);
    st(13'h0ac0, 4'h5);
    chk("int_context_regs", 32'ha, {28'h0, int_context_regs});
  endtask : t_table_op_return_int

  task automatic t_gate_idle();
    slot(13'h0ac0, 16'h38f0);
    chk("gate on", 32'h1, {31'h0, global_int_gate});
    slot(13'h0ac1, 16'h39f0);
    chk("gate off", 32'h0, {31'h0, global_int_gate});
    slot(13'h0ac2, 16'h3cf0);
    st(13'h0ac3, 4'h5);
    chk("idle keeps", 32'h1a, {26'h0, global_int_gate, system_call_flag,
                               int_context_regs});
  endtask : t_gate_idle

  // Stop then wait; a slot offered while asleep must be ignored
  task automatic t_stop_wait();
    logic [15:0] w [2];
    w[0] = 16'h3af6;
    w[1] = 16'h3bf9;
    for (int i = 0; i < 2; i++) begin
      slot(13'h0ac3 + 13'(i), w[i]);
      chk("sleep state", (i == 0) ? 32'h2 : 32'h1, {30'h0, stop_active, wait_active});
      chk("wake_cond", {28'h0, w[i][3:0]}, {28'h0, wake_cond});
      slot(13'h0ac4 + 13'(i), 16'he000);
      st(13'h0ac4 + 13'(i), 4'h5);
      wake();
      chk("awake", 32'h0, {30'h0, stop_active, wait_active});
    end
  endtask : t_stop_wait

  task automatic t_pages();
    logic [12:0] pc;
    pc = 13'h0ac5;
    for (int p = 0; p < 4; p++) begin
      slot(pc, {bcd_pkg::OPC_JUMP_HIGH, p[1:0], 11'h100 + p[10:0]});
      pc = {p[1:0], 11'h100 + p[10:0]};
      st(pc, 4'h5);
    end
  endtask : t_pages

  // Three idle words taken on consecutive edges
  task automatic t_back_to_back();
    @(posedge clock);
    instr_valid <= 1'b1;
    repeat (3) @(posedge clock);
    instr_valid <= 1'b0;
    #1;
    st(13'h1906, 4'h5);
    rd(bcd_pkg::REG_STATUS, 32'h0025_1906);
  endtask : t_back_to_back

  // Indirect call, skipping return and the skipped word on consecutive edges
  task automatic t_chain();
    pm.mem[13'h1906] = 16'h3850;
    pm.mem[13'h1a55] = 16'h39e0;
    pm.mem[13'h1907] = 16'he000;
    @(posedge clock);
    instr_valid <= 1'b1;
    repeat (3) @(posedge clock);
    instr_valid <= 1'b0;
    #1;
    st(13'h1908, 4'h5);
  endtask : t_chain

  // A reset in mid-run brings every output back to its idle value
  task automatic t_mid_reset();
    @(posedge clock);
    sys_rst <= 1'b1;
    @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    #1;
    st(13'h0000, 4'h5);
    chk("reset outputs", 32'h0, {20'h0, global_int_gate, system_call_flag, int_context_regs,
                                 stop_active, wait_active, wake_cond});
    chk("reset reg_rdata", 32'h0, reg_rdata);
    rd(bcd_pkg::REG_JUMP_TARGET, 32'h0);
  endtask : t_mid_reset

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    sys_rst           = 1'b1;
    instr_valid       = 1'b0;
    wake_event        = 1'b0;
    int_saved_context = 4'h0;
    reg_addr          = 4'h0;
    reg_wdata         = 32'h0;
    reg_write         = 1'b0;
    reg_read          = 1'b0;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    #1;
    t_reset_regs();
    t_jumps_calls();
    t_skip();
    t_table_op_return_int();
    t_gate_idle();
    t_stop_wait();
    t_pages();
    t_back_to_back();
    t_chain();
    t_mid_reset();
    summarize();
  end
endmodule : test_bcd_branch_decoder
